// ### src/tcs_keeper.sv
// Test configuration state keeper, one state per test-capable logical secure element
// What this block does
// - State is a two-valued enum: active or inactive only.
// - Active only when criterion satisfied; otherwise inactive.
// - Criterion data modified to mismatch forces inactive.
// - Activation happens only on explicit activate pulse.
// - State restored from and written to nonvolatile store.
// - After power reset, active state re-checked at init; mismatch clears.
// - All first-level applications must match before activation.
// - Independent state per test-capable secure element.
// - Successful activation drives visible parameter to one.
// - Any drop to inactive drives visible parameter to zero.
// - Current state reported on the control-parameter output.
// - Activation request on mismatch leaves state inactive.
// - Inactive stays inactive on data update or power reset.
// - Unrelated update keeps state; matching update keeps active.
// - Personalization with test configuration leaves state inactive.
// - Test functions enabled only while state active.
// - Elements without test capability hold no state.
// - Match is network access application data equals stored criterion.
`timescale 1ns/1ps
module tcs_keeper
   import tcs_pkg::*;
(
   input  wire logic                                     mclk,
   input  wire logic                                     rst_n,
   input  wire logic                                     clk_en,
   input  wire tcs_event_t [TCS_NUM_ELEMENTS-1:0]        events,
   input  wire logic [TCS_NUM_ELEMENTS-1:0][TCS_NUM_APPS-1:0][TCS_CRIT_W-1:0] app_crit_data,
   input  wire logic [TCS_NUM_ELEMENTS-1:0][TCS_CRIT_W-1:0]                   stored_crit,
   input  wire logic [TCS_NUM_ELEMENTS-1:0]              nv_state,
   input  wire logic                                     nv_valid,
   output logic [TCS_NUM_ELEMENTS-1:0]                   nv_write,
   output logic [TCS_NUM_ELEMENTS-1:0]                   nv_wdata,
   output logic [TCS_NUM_ELEMENTS-1:0]                   fcp_test_state,
   output logic [TCS_NUM_ELEMENTS-1:0]                   test_func_en
);
   logic loaded;
   logic next_loaded;

   always_comb begin
      next_loaded = loaded;
      if (clk_en && nv_valid) begin
         next_loaded = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         loaded <= 1'b0;
      end else begin
         loaded <= next_loaded;
      end
   end

   typedef enum logic [1:0] {
      TCS_ACT_NONE,
      TCS_ACT_RESTORE,
      TCS_ACT_ARM,
      TCS_ACT_DROP
   } tcs_act_t;

   genvar e;
   generate
      for (e = 0; e < TCS_NUM_ELEMENTS; e++) begin : g_elem
         if (TCS_TEST_CAPABLE[e]) begin : g_cap
            tcs_state_t                  state;
            tcs_state_t                  next_state;
            tcs_state_t                  restore_val;
            tcs_act_t                    act;

            logic [TCS_NUM_APPS-1:0]     app_match;
            logic                        match;

            logic                        ev_act;
            logic                        ev_upd;
            logic                        ev_rel;
            logic                        ev_init;
            logic                        ev_pers;

            logic                        live;
            logic                        restore;
            logic                        act_ok;
            logic                        upd_drop;
            logic                        init_drop;
            logic                        drop;

            logic                        wr;
            logic                        next_wr;
            logic                        wdata;
            logic                        next_wdata;
            logic                        file_control_parameters;
            logic                        next_fcp;
            logic                        func_en;
            logic                        next_func_en;

            // Every application on the element has to agree
            for (genvar a = 0; a < TCS_NUM_APPS; a++) begin : g_app
               assign app_match[a] = (app_crit_data[e][a] == stored_crit[e]);
            end

            always_comb begin
               match = &app_match;
            end

            // Unpacked once so the conditions below read plainly
            always_comb begin
               ev_act  = events[e].activate;
               ev_upd  = events[e].data_update;
               ev_rel  = events[e].crit_related;
               ev_init = events[e].init_check;
               ev_pers = events[e].personalize;
            end

            // Events only count once the stored state is back
            always_comb begin
               live    = clk_en && loaded;
               restore = clk_en && !loaded && nv_valid;
            end

            // Personalization in the same cycle vetoes activation
            always_comb begin
               act_ok = 1'b0;
               if (live && ev_act && match && !ev_pers) begin
                  act_ok = 1'b1;
               end
            end

            // An update unrelated to the criterion is ignored
            always_comb begin
               upd_drop = 1'b0;
               if (live && ev_upd && ev_rel && !match) begin
                  upd_drop = 1'b1;
               end
            end

            // Init check only matters while active; the case below gates it
            always_comb begin
               init_drop = 1'b0;
               if (live && ev_init && !match) begin
                  init_drop = 1'b1;
               end
            end

            // Either route out of active
            always_comb begin
               drop = upd_drop || init_drop;
            end

            // Stored bit decoded back into one of the two legal states
            always_comb begin
               restore_val = TCS_INACTIVE;
               if (nv_state[e]) begin
                  restore_val = TCS_ACTIVE;
               end
            end

            // Restore outranks; arm and drop need opposite match results
            always_comb begin
               act = TCS_ACT_NONE;
               if (restore) begin
                  act = TCS_ACT_RESTORE;
               end else if (act_ok) begin
                  act = TCS_ACT_ARM;
               end else if (drop) begin
                  act = TCS_ACT_DROP;
               end
            end

            always_comb begin
               next_state = state;
               case (state)
                  TCS_INACTIVE: begin
                     // Updates, init checks and personalization never activate
                     case (act)
                        TCS_ACT_RESTORE: begin
                           next_state = restore_val;
                        end
                        TCS_ACT_ARM: begin
                           next_state = TCS_ACTIVE;
                        end
                        default: begin
                           next_state = TCS_INACTIVE;
                        end
                     endcase
                  end
                  TCS_ACTIVE: begin
                     case (act)
                        TCS_ACT_RESTORE: begin
                           next_state = restore_val;
                        end
                        TCS_ACT_DROP: begin
                           next_state = TCS_INACTIVE;
                        end
                        default: begin
                           next_state = TCS_ACTIVE;
                        end
                     endcase
                  end
                  default: begin
                     // Unreachable with two codes; kept as the safe fallback
                     next_state = TCS_INACTIVE;
                  end
               endcase
            end

            // State and outputs all move on the edge after the event
            always_ff @(posedge mclk or negedge rst_n) begin
               if (!rst_n) begin
                  state <= TCS_INACTIVE;
               end else begin
                  state <= next_state;
               end
            end

            // Restore is a read, so it never echoes a write back to the store
            always_comb begin
               next_wr = 1'b0;
               if (act != TCS_ACT_RESTORE) begin
                  if (next_state != state) begin
                     next_wr = 1'b1;
                  end
               end
            end

            always_ff @(posedge mclk or negedge rst_n) begin
               if (!rst_n) begin
                  wr <= 1'b0;
               end else begin
                  wr <= next_wr;
               end
            end

            // Write data mirrors the value that goes out with the write
            always_comb begin
               next_wdata = wdata;
               if (next_state == TCS_ACTIVE) begin
                  next_wdata = TCS_PARAM_TRUE;
               end else begin
                  next_wdata = TCS_PARAM_FALSE;
               end
            end

            always_ff @(posedge mclk or negedge rst_n) begin
               if (!rst_n) begin
                  wdata <= TCS_PARAM_FALSE;
               end else begin
                  wdata <= next_wdata;
               end
            end

            // Visible parameter follows the state it is about to take
            always_comb begin
               next_fcp = file_control_parameters;
               if (next_state == TCS_ACTIVE) begin
                  next_fcp = TCS_PARAM_TRUE;
               end else begin
                  next_fcp = TCS_PARAM_FALSE;
               end
            end

            always_ff @(posedge mclk or negedge rst_n) begin
               if (!rst_n) begin
                  file_control_parameters <= TCS_PARAM_FALSE;
               end else begin
                  file_control_parameters <= next_fcp;
               end
            end

            // Registered so the gate never glitches on a state change
            always_comb begin
               next_func_en = 1'b0;
               if (next_state == TCS_ACTIVE) begin
                  next_func_en = 1'b1;
               end else begin
                  next_func_en = 1'b0;
               end
            end

            always_ff @(posedge mclk or negedge rst_n) begin
               if (!rst_n) begin
                  func_en <= 1'b0;
               end else begin
                  func_en <= next_func_en;
               end
            end

            // Write pulse and data leave together from flops
            assign nv_write[e]       = wr;
            assign nv_wdata[e]       = wdata;
            assign fcp_test_state[e] = file_control_parameters;
            assign test_func_en[e]   = func_en;
         end else begin : g_nocap
            // No state exists without test capability
            assign nv_write[e]       = 1'b0;
            assign nv_wdata[e]       = 1'b0;
            assign fcp_test_state[e] = TCS_PARAM_FALSE;
            assign test_func_en[e]   = 1'b0;
         end
      end
   endgenerate
endmodule // tcs_keeper

// ### common/tcs_pkg.sv
// Package for the test configuration state keeper
package tcs_pkg;
   localparam int unsigned TCS_NUM_ELEMENTS = 2;
   localparam int unsigned TCS_NUM_APPS     = 2;
   localparam int unsigned TCS_CRIT_W       = 32;
   localparam logic        TCS_PARAM_TRUE   = 1'b1;
   localparam logic        TCS_PARAM_FALSE  = 1'b0;
   localparam logic [TCS_NUM_ELEMENTS-1:0] TCS_TEST_CAPABLE = 2'h3;

   typedef enum logic {
      TCS_INACTIVE,
      TCS_ACTIVE
   } tcs_state_t;

   typedef struct packed {
      logic activate;
      logic data_update;
      logic crit_related;
      logic init_check;
      logic personalize;
   } tcs_event_t;
endpackage

// ### testbench/tcs_keeper_assertions.sv
// Checker for the test configuration state keeper
`timescale 1ns/1ps
module tcs_keeper_assertions
   import tcs_pkg::*;
#(parameter int E = TCS_NUM_ELEMENTS, parameter int A = TCS_NUM_APPS, parameter int W = TCS_CRIT_W)
(
   input wire logic                        mclk,
   input wire logic                        rst_n,
   input wire logic                        clk_en,
   input wire tcs_event_t [E-1:0]          events,
   input wire logic [E-1:0][A-1:0][W-1:0]  app_crit_data,
   input wire logic [E-1:0][W-1:0]         stored_crit,
   input wire logic [E-1:0]                nv_state,
   input wire logic                        nv_valid,
   input wire logic [E-1:0]                nv_write,
   input wire logic [E-1:0]                nv_wdata,
   input wire logic [E-1:0]                fcp_test_state,
   input wire logic [E-1:0]                test_func_en
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic ld;
   wire tcs_event_t ev = events[0];
   wire m = app_crit_data[0][0] == stored_crit[0] && app_crit_data[0][1] == stored_crit[0];
   wire go = clk_en && ld;
   wire act = go && ev.activate && m && !ev.personalize;
   wire drop = go && !m && (ev.init_check || ev.data_update && ev.crit_related);
   sequence s_restore; clk_en && nv_valid && !ld; endsequence
   // Events count only once the stored state is back
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ld <= 1'b0;
      end else if (clk_en && nv_valid) begin
         ld <= 1'b1;
      end
   end
   a_act_sets: assert property (act |=> fcp_test_state[0]) else $error("activation missed");
   a_stay_off: assert property (!fcp_test_state[0] && !act && !(clk_en && nv_valid && !ld) |=> !fcp_test_state[0])
      else $error("implicit activation");
   a_drop_off: assert property (drop |=> !fcp_test_state[0] && !test_func_en[0]) else $error("drop missed");
   a_keep_on: assert property (fcp_test_state[0] && !drop && !(go && ev.personalize) |=> fcp_test_state[0])
      else $error("active state lost");
   a_func_gate: assert property (test_func_en == fcp_test_state) else $error("test functions mismatch");
   a_nv_track: assert property ($changed(fcp_test_state[0]) && $past(ld) |-> nv_write[0] && nv_wdata[0] == fcp_test_state[0])
      else $error("change not stored");
   a_write_data: assert property (nv_write != '0 |-> nv_wdata == fcp_test_state) else $error("stored value wrong");
   a_write_edge: assert property (nv_write[1] |-> $changed(fcp_test_state[1])) else $error("write without change");
   a_freeze_off: assert property (!clk_en |=> $stable(fcp_test_state)) else $error("state moved while frozen");
   a_restore_nv: assert property (s_restore |=> fcp_test_state[0] == $past(nv_state[0])) else $error("restore wrong");
endmodule // tcs_keeper_assertions
bind tcs_keeper tcs_keeper_assertions u_chk (.*);

// ### testbench/tcs_nv_model.sv
// Nonvolatile store model on the far side of the keeper
`timescale 1ns/1ps
module tcs_nv_model
   import tcs_pkg::*;
(
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   input  wire logic [TCS_NUM_ELEMENTS-1:0] nv_write,
   input  wire logic [TCS_NUM_ELEMENTS-1:0] nv_wdata,
   output logic [TCS_NUM_ELEMENTS-1:0]      nv_state = '0,
   output logic                             nv_valid
);
   // No reset here: contents must outlive a power cycle
   always @(posedge mclk) nv_state <= nv_state & ~nv_write | nv_wdata & nv_write;
   always @(posedge mclk or negedge rst_n) nv_valid <= rst_n;
endmodule // tcs_nv_model

// ### testbench/tb.sv
// Random bench for the keeper over several power cycles
`timescale 1ns/1ps
module tb;
   import tcs_pkg::*;
   logic mclk = 0, rst_n = 0, clk_en = 0, nv_valid, ld, m, hit;
   tcs_event_t [1:0] events = '0;
   logic [1:0][1:0][31:0] app_crit_data = '0;
   logic [1:0][31:0] stored_crit = '0;
   logic [1:0] nv_state, nv_write, nv_wdata, fcp_test_state, test_func_en, st = '0;
   int fail_count = 0, tests_run = 0, seed = 32'h6e6f;
   initial forever #2.5 mclk = ~mclk;
   tcs_keeper uut (.*);
   tcs_nv_model u_nv (.*);
   function automatic logic nxt(logic s, tcs_event_t e, logic mt);
      if (e.activate && mt && !e.personalize) return 1'b1;
      if (!mt && (e.init_check || e.data_update && e.crit_related)) return 1'b0;
      return s;
   endfunction
   task automatic chk(string n, logic [1:0] exp, logic [1:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      for (int p = 0; p < 4; p++) begin
         rst_n = 0;
         ld = 0;
         stored_crit = {$random(seed), $random(seed)};
         repeat (12) @(negedge mclk);
         rst_n = 1;
         for (int i = 0; i < 300; i++) begin
            @(negedge mclk);
            chk("fcp_test_state", ld ? st : 2'h0, fcp_test_state);
            chk("test_func_en", ld ? st : 2'h0, test_func_en);
            hit = i % 50 == 20;
            clk_en = hit || $random(seed) % 8 != 0;
            for (int e = 0; e < 2; e++) begin
               m = 1;
               events[e] = hit ? 5'h10 : (i < 290 ? 5'($random(seed)) : 5'h0);
               for (int a = 0; a < 2; a++) begin
                  app_crit_data[e][a] = stored_crit[e] ^ 32'(!hit && $random(seed) % 4 == 0);
                  m &= app_crit_data[e][a] == stored_crit[e];
               end
               if (clk_en && ld) st[e] = nxt(st[e], events[e], m);
            end
            if (clk_en && nv_valid) ld = 1;
         end
      end
      summarize();
   end
endmodule // tb
